// file: codec_bias_pkg.sv
// Constants for the bias and mid-rail control register bank
package codec_bias_pkg;

  // ==========================================================================
  // Register indices on the control port
  localparam logic [7:0] ADDR_RESET_IDENTITY = 8'h00;
  localparam logic [7:0] ADDR_SILICON_REV    = 8'h01;
  localparam logic [7:0] ADDR_BIAS_CONTROL   = 8'h04;
  localparam logic [7:0] ADDR_MIDRAIL_CTRL   = 8'h05;
  localparam logic [7:0] ADDR_MIC_BIAS_CTRL  = 8'h06;
  localparam logic [7:0] ADDR_DAC_BIAS       = 8'h08;

  // ==========================================================================
  // Identity values (arbitrary neutral values)
  localparam logic [15:0] IDENTITY_DEFAULT = 16'h5a17;
  localparam logic [3:0]  REVISION_DEFAULT = 4'h3;

  // ==========================================================================
  // Field positions
  localparam int BIAS_SRC_BIT     = 4;
  localparam int BIAS_SCALE_LO    = 2;
  localparam int BIAS_STARTUP_BIT = 1;
  localparam int BIAS_NORMAL_BIT  = 0;
  localparam int MID_TIE_BIT      = 7;
  localparam int MID_UNUSED_BIT   = 6;
  localparam int MID_STARTUP_BIT  = 5;
  localparam int MID_SOFT_LO      = 3;
  localparam int MID_DIV_LO       = 1;
  localparam int MID_BUF_BIT      = 0;
  localparam int MIC_INSERT_LO    = 4;
  localparam int MIC_BUTTON_LO    = 2;
  localparam int MIC_DETECT_BIT   = 1;
  localparam int MIC_SUPPLY_BIT   = 0;
  localparam int DAC_BOOST_BIT    = 5;
  localparam int DAC_SCALE_LO     = 3;
  localparam int DAC_MID_LO       = 1;

  // ==========================================================================
  // Writable bit masks and reset values
  localparam logic [15:0] BIAS_MASK    = 16'h001f;
  localparam logic [15:0] MID_MASK     = 16'h00ff;
  localparam logic [15:0] MIC_MASK     = 16'h003f;
  localparam logic [15:0] DAC_MASK     = 16'h003e;
  localparam logic [15:0] BIAS_RESET   = 16'h0018;
  localparam logic [15:0] MID_RESET    = 16'h0000;
  localparam logic [15:0] MIC_RESET    = 16'h0000;
  localparam logic [15:0] DAC_RESET    = 16'h0000;

  // ==========================================================================
  // Field encodings
  localparam logic [1:0] SCALE_HALF      = 2'h0;
  localparam logic [1:0] SCALE_3Q        = 2'h1;
  localparam logic [1:0] SCALE_NORMAL    = 2'h2;
  localparam logic [1:0] SCALE_1P5       = 2'h3;
  localparam logic [1:0] SOFT_OFF        = 2'h0;
  localparam logic [1:0] SOFT_FAST       = 2'h1;
  localparam logic [1:0] SOFT_NOMINAL    = 2'h2;
  localparam logic [1:0] SOFT_SLOW       = 2'h3;
  localparam logic [1:0] DIV_OFF         = 2'h0;
  localparam logic [1:0] DIV_50K         = 2'h1;
  localparam logic [1:0] DIV_250K        = 2'h2;
  localparam logic [1:0] DIV_5K          = 2'h3;
  localparam logic [1:0] DAC_NORMAL      = 2'h0;
  localparam logic [1:0] DAC_HALF        = 2'h1;
  localparam logic [1:0] DAC_066         = 2'h2;
  localparam logic [1:0] DAC_075         = 2'h3;

endpackage

// file: codec_bias_midrail_control_regs.sv
// Bias, mid-rail, microphone bias and DAC bias control register bank
//
// Design decision made here: the address-and-strobe port.

module codec_bias_midrail_control_regs
  import codec_bias_pkg::*;
#(
  parameter logic [15:0] IDENTITY_CODE = IDENTITY_DEFAULT,
  parameter logic [3:0]  REVISION_CODE = REVISION_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        spk_left_enable_i,
  input  wire logic        spk_right_enable_i,
  output logic      [15:0] rdata_o,
  output logic             output_bias_source_sel_o,
  output logic      [1:0]  master_bias_scale_o,
  output logic             startup_bias_on_o,
  output logic             normal_bias_enable_o,
  output logic             midrail_tie_lineout_left_o,
  output logic             midrail_tie_lineout_right_o,
  output logic             midrail_unused_pin_enable_o,
  output logic      [1:0]  midrail_soft_start_rate_o,
  output logic      [1:0]  midrail_divider_sel_o,
  output logic             midrail_buffer_enable_o,
  output logic      [1:0]  mic_insert_threshold_o,
  output logic      [1:0]  mic_button_threshold_o,
  output logic             mic_detect_enable_o,
  output logic             mic_supply_enable_o,
  output logic      [1:0]  dac_current_scale_o,
  output logic      [1:0]  dac_midrail_buffer_scale_o,
  output logic             dac_bias_boost_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        spk_l_meta;
    logic        spk_r_meta;
    logic        spk_l_sync;
    logic        spk_r_sync;
    logic [15:0] bias;
    logic [15:0] mid;
    logic [15:0] mic;
    logic [15:0] dac;
    logic [15:0] rdata;
    logic        src_sel;
    logic [1:0]  master_scale;
    logic        startup_on;
    logic        normal_on;
    logic        tie_l;
    logic        tie_r;
    logic        unused_tie;
    logic [1:0]  soft_rate;
    logic [1:0]  div_sel;
    logic        buf_on;
    logic [1:0]  mic_ins;
    logic [1:0]  mic_btn;
    logic        mic_det;
    logic        mic_sup;
    logic [1:0]  dac_scale;
    logic [1:0]  dac_mid;
    logic        dac_boost;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Masked register update keeping unassigned bits at zero
  function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
    return d & m;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Speaker enables come from another block's pins, synchronised twice
    st_nxt.spk_l_meta = spk_left_enable_i;
    st_nxt.spk_r_meta = spk_right_enable_i;
    st_nxt.spk_l_sync = st_r.spk_l_meta;
    st_nxt.spk_r_sync = st_r.spk_r_meta;
    // Register writes
    if (wr_i) begin
      case (addr_i)
        ADDR_RESET_IDENTITY: begin
          st_nxt.bias = BIAS_RESET;
          st_nxt.mid  = MID_RESET;
          st_nxt.mic  = MIC_RESET;
          st_nxt.dac  = DAC_RESET;
        end
        ADDR_BIAS_CONTROL:  st_nxt.bias = masked(wdata_i, BIAS_MASK);
        ADDR_MIDRAIL_CTRL:  st_nxt.mid  = masked(wdata_i, MID_MASK);
        ADDR_MIC_BIAS_CTRL: st_nxt.mic  = masked(wdata_i, MIC_MASK);
        ADDR_DAC_BIAS:      st_nxt.dac  = masked(wdata_i, DAC_MASK);
        default: ;
      endcase
    end
    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        ADDR_RESET_IDENTITY: st_nxt.rdata = IDENTITY_CODE;
        ADDR_SILICON_REV:    st_nxt.rdata = {12'h000, REVISION_CODE};
        ADDR_BIAS_CONTROL:   st_nxt.rdata = st_r.bias;
        ADDR_MIDRAIL_CTRL:   st_nxt.rdata = st_r.mid;
        ADDR_MIC_BIAS_CTRL:  st_nxt.rdata = st_r.mic;
        ADDR_DAC_BIAS:       st_nxt.rdata = st_r.dac;
        default:             st_nxt.rdata = 16'h0000;
      endcase
    end
    // Control outputs decoded from the registered fields
    st_nxt.src_sel      = st_r.bias[BIAS_SRC_BIT];
    st_nxt.master_scale = st_r.bias[BIAS_SCALE_LO +: 2];
    st_nxt.startup_on   = st_r.bias[BIAS_STARTUP_BIT] | st_r.mid[MID_STARTUP_BIT];
    st_nxt.normal_on    = st_r.bias[BIAS_NORMAL_BIT];
    st_nxt.tie_l        = st_r.mid[MID_TIE_BIT] & ~st_r.spk_l_sync;
    st_nxt.tie_r        = st_r.mid[MID_TIE_BIT] & ~st_r.spk_r_sync;
    st_nxt.unused_tie   = st_r.mid[MID_UNUSED_BIT];
    st_nxt.soft_rate    = st_r.mid[MID_SOFT_LO +: 2];
    st_nxt.div_sel      = st_r.mid[MID_DIV_LO +: 2];
    st_nxt.buf_on       = st_r.mid[MID_BUF_BIT];
    st_nxt.mic_ins      = st_r.mic[MIC_INSERT_LO +: 2];
    st_nxt.mic_btn      = st_r.mic[MIC_BUTTON_LO +: 2];
    st_nxt.mic_det      = st_r.mic[MIC_DETECT_BIT];
    st_nxt.mic_sup      = st_r.mic[MIC_SUPPLY_BIT];
    st_nxt.dac_scale    = st_r.dac[DAC_SCALE_LO +: 2];
    st_nxt.dac_mid      = st_r.dac[DAC_MID_LO +: 2];
    st_nxt.dac_boost    = st_r.dac[DAC_BOOST_BIT];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r              <= '0;
      st_r.bias         <= BIAS_RESET;
      st_r.src_sel      <= BIAS_RESET[BIAS_SRC_BIT];
      st_r.master_scale <= BIAS_RESET[BIAS_SCALE_LO +: 2];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata_o                     = st_r.rdata;
  assign output_bias_source_sel_o    = st_r.src_sel;
  assign master_bias_scale_o         = st_r.master_scale;
  assign startup_bias_on_o           = st_r.startup_on;
  assign normal_bias_enable_o        = st_r.normal_on;
  assign midrail_tie_lineout_left_o  = st_r.tie_l;
  assign midrail_tie_lineout_right_o = st_r.tie_r;
  assign midrail_unused_pin_enable_o = st_r.unused_tie;
  assign midrail_soft_start_rate_o   = st_r.soft_rate;
  assign midrail_divider_sel_o       = st_r.div_sel;
  assign midrail_buffer_enable_o     = st_r.buf_on;
  assign mic_insert_threshold_o      = st_r.mic_ins;
  assign mic_button_threshold_o      = st_r.mic_btn;
  assign mic_detect_enable_o         = st_r.mic_det;
  assign mic_supply_enable_o         = st_r.mic_sup;
  assign dac_current_scale_o         = st_r.dac_scale;
  assign dac_midrail_buffer_scale_o  = st_r.dac_mid;
  assign dac_bias_boost_o            = st_r.dac_boost;

  // ==========================================================================
  // Checks
  sequence wr_sw_reset_s;
    wr_i && addr_i == ADDR_RESET_IDENTITY;
  endsequence

  sequence reg_defaults_s;
    st_r.bias == BIAS_RESET && st_r.mid == MID_RESET && st_r.mic == MIC_RESET && st_r.dac == DAC_RESET;
  endsequence

  soft_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_sw_reset_s |=> reg_defaults_s) else $error("soft reset did not restore defaults");

  identity_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_RESET_IDENTITY |=> rdata_o == IDENTITY_CODE) else $error("identity read wrong");

  revision_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_SILICON_REV |=> rdata_o == {12'h000, REVISION_CODE}) else $error("revision read wrong");

  bias_source_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ADDR_BIAS_CONTROL |=> ##1 output_bias_source_sel_o == $past(wdata_i[BIAS_SRC_BIT], 2))
    else $error("bias source select wrong");

  master_scale_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_sw_reset_s |=> ##1 master_bias_scale_o == SCALE_NORMAL) else $error("master scale not normal after reset");

  startup_alias_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ADDR_MIDRAIL_CTRL && wdata_i[MID_STARTUP_BIT] |=> ##1 startup_bias_on_o)
    else $error("start-up alias bit ignored");

  normal_bias_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    normal_bias_enable_o == $past(st_r.bias[BIAS_NORMAL_BIT])) else $error("normal bias enable mismatch");

  tie_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.spk_l_sync |=> !midrail_tie_lineout_left_o) else $error("tie active while speaker on");

  unused_tie_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ADDR_MIDRAIL_CTRL |=> ##1 midrail_unused_pin_enable_o == $past(wdata_i[MID_UNUSED_BIT], 2))
    else $error("unused pin tie wrong");

  soft_div_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_sw_reset_s |=> ##1 midrail_soft_start_rate_o == SOFT_OFF && midrail_divider_sel_o == DIV_OFF)
    else $error("mid-rail fields not cleared");

  mic_fields_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ADDR_MIC_BIAS_CTRL |=> ##1
      {mic_insert_threshold_o, mic_button_threshold_o, mic_detect_enable_o, mic_supply_enable_o}
      == $past(wdata_i[5:0], 2)) else $error("mic fields wrong");

  dac_fields_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == ADDR_DAC_BIAS |=> ##1
      {dac_bias_boost_o, dac_current_scale_o, dac_midrail_buffer_scale_o} == $past(wdata_i[5:1], 2))
    else $error("dac fields wrong");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_DAC_BIAS |=> rdata_o[0] == 1'b0 && rdata_o[15:6] == 10'h000)
    else $error("reserved bits not zero");

  // ==========================================================================
  // Register store checks, one access at a time
  sequence wr_bias_s;
    wr_i && addr_i == ADDR_BIAS_CONTROL;
  endsequence

  sequence wr_mid_s;
    wr_i && addr_i == ADDR_MIDRAIL_CTRL;
  endsequence

  sequence wr_mic_s;
    wr_i && addr_i == ADDR_MIC_BIAS_CTRL;
  endsequence

  sequence wr_dac_s;
    wr_i && addr_i == ADDR_DAC_BIAS;
  endsequence

  sequence wr_rev_s;
    wr_i && addr_i == ADDR_SILICON_REV;
  endsequence

  // A write lands in the next cycle with unassigned bits dropped
  bias_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_bias_s |=> st_r.bias == ($past(wdata_i) & BIAS_MASK)) else $error("bias register store wrong");

  mid_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mid_s |=> st_r.mid == ($past(wdata_i) & MID_MASK)) else $error("mid-rail register store wrong");

  mic_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mic_s |=> st_r.mic == ($past(wdata_i) & MIC_MASK)) else $error("mic register store wrong");

  dac_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_dac_s |=> st_r.dac == ($past(wdata_i) & DAC_MASK)) else $error("dac register store wrong");

  // Revision writes must leave every stored register alone
  rev_write_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_rev_s |=> $stable(st_r.bias) && $stable(st_r.mid) && $stable(st_r.mic) && $stable(st_r.dac))
    else $error("revision write changed a register");

  // ==========================================================================
  // Read-back checks
  bias_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_BIAS_CONTROL |=> rdata_o == $past(st_r.bias)) else $error("bias read-back wrong");

  mid_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_MIDRAIL_CTRL |=> rdata_o == $past(st_r.mid)) else $error("mid-rail read-back wrong");

  mic_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_MIC_BIAS_CTRL |=> rdata_o == $past(st_r.mic)) else $error("mic read-back wrong");

  // Read data stands for one cycle only, zero otherwise
  rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == '0) else $error("read data not cleared");

  // ==========================================================================
  // Unassigned bits never hold a one
  bias_spare_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r.bias & ~BIAS_MASK) == '0) else $error("bias spare bit set");

  mid_spare_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r.mid & ~MID_MASK) == '0) else $error("mid-rail spare bit set");

  mic_spare_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r.mic & ~MIC_MASK) == '0) else $error("mic spare bit set");

  dac_spare_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r.dac & ~DAC_MASK) == '0) else $error("dac spare bit set");

  // ==========================================================================
  // Field outputs follow the stored registers one cycle later
  src_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    output_bias_source_sel_o == $past(st_r.bias[BIAS_SRC_BIT])) else $error("source select lags wrong");

  scale_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    master_bias_scale_o == $past(st_r.bias[BIAS_SCALE_LO +: 2])) else $error("master scale lags wrong");

  startup_or_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    startup_bias_on_o == $past(st_r.bias[BIAS_STARTUP_BIT] | st_r.mid[MID_STARTUP_BIT]))
    else $error("start-up enable not the or of both bits");

  // Tie gating on each side by its own speaker enable
  tie_right_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.spk_r_sync |=> !midrail_tie_lineout_right_o) else $error("right tie active while speaker on");

  tie_open_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.mid[MID_TIE_BIT] && !st_r.spk_l_sync |=> midrail_tie_lineout_left_o)
    else $error("left tie missing while speaker off");

  soft_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    midrail_soft_start_rate_o == $past(st_r.mid[MID_SOFT_LO +: 2])) else $error("soft start rate lags wrong");

  div_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    midrail_divider_sel_o == $past(st_r.mid[MID_DIV_LO +: 2])) else $error("divider select lags wrong");

  ins_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mic_insert_threshold_o == $past(st_r.mic[MIC_INSERT_LO +: 2])) else $error("insert threshold lags wrong");

  btn_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mic_button_threshold_o == $past(st_r.mic[MIC_BUTTON_LO +: 2])) else $error("button threshold lags wrong");

  det_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mic_detect_enable_o == $past(st_r.mic[MIC_DETECT_BIT]) && mic_supply_enable_o == $past(st_r.mic[MIC_SUPPLY_BIT]))
    else $error("mic enables lag wrong");

  boost_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dac_bias_boost_o == $past(st_r.dac[DAC_BOOST_BIT])) else $error("dac boost lags wrong");

  dac_scale_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dac_current_scale_o == $past(st_r.dac[DAC_SCALE_LO +: 2])) else $error("dac scale lags wrong");

  dac_mid_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dac_midrail_buffer_scale_o == $past(st_r.dac[DAC_MID_LO +: 2])) else $error("dac buffer scale lags wrong");

  // Unused pin tie follows its bit with the same one-cycle lag
  unused_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    midrail_unused_pin_enable_o == $past(st_r.mid[MID_UNUSED_BIT])) else $error("unused pin tie lags wrong");

endmodule

// file: testbench.sv
// Self-checking testbench for the bias and mid-rail control register bank
module testbench
  import codec_bias_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Stimulus, observation and bookkeeping
  logic        clk_i;
  logic        rst_n_i;
  logic [7:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic        spk_l;
  logic        spk_r;
  logic [15:0] rdata_o;
  logic [23:0] outs;
  logic [15:0] bias_m, mid_m, mic_m, dac_m;
  int          n_fail;
  int          n_checks;

  codec_bias_midrail_control_regs dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .spk_left_enable_i(spk_l), .spk_right_enable_i(spk_r), .rdata_o(rdata_o),
    .output_bias_source_sel_o(outs[23]), .master_bias_scale_o(outs[22:21]), .startup_bias_on_o(outs[20]),
    .normal_bias_enable_o(outs[19]), .midrail_tie_lineout_left_o(outs[18]),
    .midrail_tie_lineout_right_o(outs[17]), .midrail_unused_pin_enable_o(outs[16]),
    .midrail_soft_start_rate_o(outs[15:14]), .midrail_divider_sel_o(outs[13:12]),
    .midrail_buffer_enable_o(outs[11]), .mic_insert_threshold_o(outs[10:9]),
    .mic_button_threshold_o(outs[8:7]), .mic_detect_enable_o(outs[6]), .mic_supply_enable_o(outs[5]),
    .dac_current_scale_o(outs[3:2]), .dac_midrail_buffer_scale_o(outs[1:0]), .dac_bias_boost_o(outs[4]));

  // ==========================================================================
  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    $display("unexpected at %0t: run did not end", $time);
    tally_and_finish();
  end

  // ==========================================================================
  // Shared helpers
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic defaults_m();
    bias_m = BIAS_RESET;
    mid_m  = MID_RESET;
    mic_m  = MIC_RESET;
    dac_m  = DAC_RESET;
  endtask

  function automatic logic [15:0] get_m(input logic [7:0] a);
    case (a)
      ADDR_BIAS_CONTROL:  return bias_m;
      ADDR_MIDRAIL_CTRL:  return mid_m;
      ADDR_MIC_BIAS_CTRL: return mic_m;
      ADDR_DAC_BIAS:      return dac_m;
      default:            return 16'h0000;
    endcase
  endfunction

  // Field outputs expected from the model and the speaker enables
  function automatic logic [23:0] exp_outs();
    return {bias_m[4:2], bias_m[1] | mid_m[5], bias_m[0], mid_m[7] & ~spk_l, mid_m[7] & ~spk_r,
            mid_m[6], mid_m[4:0], mic_m[5:0], dac_m[5:1]};
  endfunction

  // One-cycle write strobe, model follows
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    case (a)
      ADDR_RESET_IDENTITY: defaults_m();
      ADDR_BIAS_CONTROL:   bias_m = d & BIAS_MASK;
      ADDR_MIDRAIL_CTRL:   mid_m  = d & MID_MASK;
      ADDR_MIC_BIAS_CTRL:  mic_m  = d & MIC_MASK;
      ADDR_DAC_BIAS:       dac_m  = d & DAC_MASK;
      default:             ;
    endcase
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Read back all four control registers against the model
  task automatic check_regs();
    logic [15:0] d;
    logic [7:0]  a [4];
    a = '{ADDR_BIAS_CONTROL, ADDR_MIDRAIL_CTRL, ADDR_MIC_BIAS_CTRL, ADDR_DAC_BIAS};
    for (int i = 0; i < 4; i++) begin
      rd(a[i], d);
      check({8'h00, d}, {8'h00, get_m(a[i])});
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    settle();
    check(outs, exp_outs());
    check_regs();
    $display("test reset_values done");
  endtask

  task automatic t_fields();
    logic [7:0]  a [4];
    logic [15:0] v [4];
    a = '{ADDR_BIAS_CONTROL, ADDR_MIDRAIL_CTRL, ADDR_MIC_BIAS_CTRL, ADDR_DAC_BIAS};
    v = '{16'h5555, 16'haaaa, 16'hffff, 16'h0000};
    // Every two-bit field sees all four codes
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) begin
        wr(a[r], v[k]);
        settle();
        check(outs, exp_outs());
        check_regs();
      end
    end
    $display("test fields done");
  endtask

  task automatic t_identity();
    logic [15:0] d;
    rd(ADDR_RESET_IDENTITY, d);
    check({8'h00, d}, {8'h00, IDENTITY_DEFAULT});
    @(posedge clk_i);
    #1 check({8'h00, rdata_o}, 24'h000000);
    wr(ADDR_SILICON_REV, 16'hffff);
    rd(ADDR_SILICON_REV, d);
    check({8'h00, d}, {20'h00000, REVISION_DEFAULT});
    wr(8'h03, 16'hffff);
    rd(8'h02, d);
    check({8'h00, d}, 24'h000000);
    check_regs();
    $display("test identity done");
  endtask

  task automatic t_startup_alias();
    wr(ADDR_BIAS_CONTROL, 16'h0000);
    wr(ADDR_MIDRAIL_CTRL, 16'h0020);
    settle();
    check({23'h0, outs[20]}, 24'h000001);
    wr(ADDR_MIDRAIL_CTRL, 16'h0000);
    settle();
    check({23'h0, outs[20]}, 24'h000000);
    wr(ADDR_BIAS_CONTROL, 16'h0002);
    settle();
    check(outs, exp_outs());
    $display("test startup_alias done");
  endtask

  task automatic t_tie_gating();
    wr(ADDR_MIDRAIL_CTRL, 16'h0080);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      spk_l <= k[1];
      spk_r <= k[0];
      repeat (4) @(posedge clk_i);
      #1 check(outs, exp_outs());
    end
    @(posedge clk_i);
    spk_l <= 1'b0;
    spk_r <= 1'b0;
    $display("test tie_gating done");
  endtask

  task automatic t_soft_reset();
    wr(ADDR_BIAS_CONTROL, 16'h0007);
    wr(ADDR_MIDRAIL_CTRL, 16'h00ff);
    wr(ADDR_MIC_BIAS_CTRL, 16'h003f);
    wr(ADDR_DAC_BIAS, 16'h003e);
    wr(ADDR_RESET_IDENTITY, 16'h0000);
    check_regs();
    settle();
    check(outs, exp_outs());
    $display("test soft_reset done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    n_fail   = 0;
    n_checks = 0;
    rst_n_i  = 1'b0;
    addr_i   = 8'h00;
    wdata_i  = 16'h0000;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    spk_l    = 1'b0;
    spk_r    = 1'b0;
    defaults_m();
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset_values();
    t_fields();
    t_identity();
    t_startup_alias();
    t_tie_gating();
    t_soft_reset();
    tally_and_finish();
  end

endmodule
